// ---- logic_eq_pkg.sv ----
// shared constants and types of the programmable logic equation bank
package logic_eq_pkg;

   // ----------------------------------------------------------------
   // register map (word addresses)
   // ----------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] CTRL_ADDR = 8'h00;
   localparam logic [ADDR_W-1:0] SWEEP_ADDR = 8'h01;
   localparam logic [ADDR_W-1:0] EQ_BASE_ADDR = 8'h10;
   localparam int EQ_STRIDE_SH = 2;
   localparam logic [1:0] EQ_SEL_WORD = 2'h0;
   localparam logic [1:0] EQ_RST_WORD = 2'h1;
   localparam logic [1:0] EQ_DLY_WORD = 2'h2;
   localparam logic [1:0] EQ_STAT_WORD = 2'h3;

   // ----------------------------------------------------------------
   // field layout
   // ----------------------------------------------------------------
   localparam int DATA_W = 32;
   localparam int N_IN = 4;
   localparam int SEL_W = 6;
   localparam int INV_LSB = 24;
   localparam int GATE_LSB = 28;
   localparam int GATE_W = 2;
   localparam int RST_INV_BIT = 8;
   localparam int OFF_DLY_LSB = 16;
   localparam int STAT_RES_BIT = 4;
   localparam int STAT_LAT_BIT = 5;
   localparam int STAT_LATN_BIT = 6;
   localparam int STAT_BUSY_BIT = 7;
   localparam int CTRL_RUN_BIT = 0;
   localparam logic [DATA_W-1:0] SEL_MASK = 32'h3FFFFFFF;
   localparam logic [DATA_W-1:0] RST_MASK = 32'h0000013F;
   localparam int SWEEP_W = 16;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic RUN_RST = 1'b1;
   localparam logic [DATA_W-1:0] SEL_RST = 32'h00000000;

   // ----------------------------------------------------------------
   // selectable signal groups
   // ----------------------------------------------------------------
   localparam int PICKUP_W = 8;
   localparam int PSTATE_W = 8;
   localparam int BREAKER_W = 4;
   localparam int ALARM_W = 4;
   localparam int MODIN_W = 8;
   localparam int N_EXT = PICKUP_W + PSTATE_W + BREAKER_W + ALARM_W + MODIN_W;

   typedef enum logic [GATE_W-1:0] {
      GATE_AND = 2'h0,
      GATE_OR = 2'h1,
      GATE_NAND = 2'h2,
      GATE_NOR = 2'h3
   } gate_t;

   typedef enum logic {
      ST_IDLE = 1'b0,
      ST_SWEEP = 1'b1
   } sweep_st_t;

endpackage : logic_eq_pkg

// ---- equation_eval.sv ----
// one equation step: input conditioning, gate, on/off timer, reset-dominant latch
`timescale 1ns/1ns
module equation_eval #(
   parameter int CNT_W = 16
) (
   // selected raw signals
   input wire logic [logic_eq_pkg::N_IN-1:0] raw_in,
   input wire logic [logic_eq_pkg::N_IN-1:0] inv,
   input wire logic_eq_pkg::gate_t gate,
   input wire logic rst_raw,
   input wire logic rst_inv,
   // timer settings and state
   input wire logic [CNT_W-1:0] assert_delay_time,
   input wire logic [CNT_W-1:0] release_delay_time,
   input wire logic [CNT_W-1:0] cnt,
   input wire logic res,
   input wire logic lat,
   // next state
   output logic [logic_eq_pkg::N_IN-1:0] cond,
   output logic [CNT_W-1:0] cnt_d,
   output logic res_d,
   output logic lat_d
);

   logic g;
   logic rst;
   logic [CNT_W-1:0] lim;
   logic [CNT_W:0] nxt;

   always_comb begin
      cond = raw_in ^ inv;
      unique case (gate)
         logic_eq_pkg::GATE_AND: g = &cond;
         logic_eq_pkg::GATE_OR: g = |cond;
         logic_eq_pkg::GATE_NAND: g = ~&cond;
         logic_eq_pkg::GATE_NOR: g = ~|cond;
      endcase
      // timer runs only while the gate differs from the held output
      lim = g ? assert_delay_time : release_delay_time;
      nxt = {1'b0, cnt} + 1'b1;
      cnt_d = '0;
      res_d = res;
      if (g != res) begin
         if (nxt >= {1'b0, lim}) begin
            res_d = g;
         end else begin
            cnt_d = nxt[CNT_W-1:0];
         end
      end
      rst = rst_raw ^ rst_inv;
      if (rst) begin
         lat_d = 1'b0;
      end else if (res_d) begin
         lat_d = 1'b1;
      end else begin
         lat_d = lat;
      end
   end

endmodule : equation_eval

// ---- logic_equations.sv ----
// bank of programmable logic equations swept in ascending order, Avalon-MM configured
//
// Local design decisions: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ns
module logic_equations #(
   parameter int N_EQ = 8,
   parameter int CNT_W = 16
) (
   // clock and reset
   input wire logic clock,
   input wire logic srst,
   // Avalon-MM slave
   input wire logic [logic_eq_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [logic_eq_pkg::DATA_W-1:0] avs_writedata,
   output logic [logic_eq_pkg::DATA_W-1:0] avs_readdata,
   output logic avs_waitrequest,
   // selectable protection signals
   input wire logic [logic_eq_pkg::PICKUP_W-1:0] prot_pickup,
   input wire logic [logic_eq_pkg::PSTATE_W-1:0] prot_state,
   input wire logic [logic_eq_pkg::BREAKER_W-1:0] breaker_state,
   input wire logic [logic_eq_pkg::ALARM_W-1:0] system_alarm,
   input wire logic [logic_eq_pkg::MODIN_W-1:0] module_input,
   // equation outputs
   output logic [N_EQ-1:0] equation_result,
   output logic [N_EQ-1:0] latched_result,
   output logic [N_EQ-1:0] latched_result_n,
   output logic sweep_tick
);

   // ----------------------------------------------------------------
   // sizes
   // ----------------------------------------------------------------
   localparam int IDX_W = (N_EQ > 1) ? $clog2(N_EQ) : 1;
   localparam int LIST_W = logic_eq_pkg::N_EXT + 3 * N_EQ;
   localparam int LIST_N = 1 << logic_eq_pkg::SEL_W;
   localparam int SW = logic_eq_pkg::SEL_W;
   localparam int NI = logic_eq_pkg::N_IN;
   localparam int DW = logic_eq_pkg::DATA_W;
   localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(N_EQ - 1);

   typedef struct packed {
      logic run;
      logic_eq_pkg::sweep_st_t st;
      logic [IDX_W-1:0] idx;
      logic [logic_eq_pkg::N_EXT-1:0] ext;
      logic [N_EQ-1:0][DW-1:0] sel;
      logic [N_EQ-1:0][SW:0] rsel;
      logic [N_EQ-1:0][CNT_W-1:0] on_dly;
      logic [N_EQ-1:0][CNT_W-1:0] off_dly;
      logic [N_EQ-1:0][CNT_W-1:0] cnt;
      logic [N_EQ-1:0][NI-1:0] cond;
      logic [N_EQ-1:0] res;
      logic [N_EQ-1:0] lat;
      logic [N_EQ-1:0] latn;
      logic [logic_eq_pkg::SWEEP_W-1:0] sweeps;
      logic tick;
      logic wait_r;
      logic [DW-1:0] rdata;
   } state_t;

   state_t s_q;
   state_t s_d;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic pick(input logic [LIST_N-1:0] list, input logic [SW-1:0] sel);
      pick = list[sel];
   endfunction : pick

   function automatic logic eq_hit(input logic [logic_eq_pkg::ADDR_W-1:0] a);
      logic [logic_eq_pkg::ADDR_W-1:0] off;
      off = a - logic_eq_pkg::EQ_BASE_ADDR;
      eq_hit = (a >= logic_eq_pkg::EQ_BASE_ADDR) &&
               ((off >> logic_eq_pkg::EQ_STRIDE_SH) < N_EQ);
   endfunction : eq_hit

   function automatic logic [IDX_W-1:0] eq_of(input logic [logic_eq_pkg::ADDR_W-1:0] a);
      logic [logic_eq_pkg::ADDR_W-1:0] off;
      off = (a - logic_eq_pkg::EQ_BASE_ADDR) >> logic_eq_pkg::EQ_STRIDE_SH;
      eq_of = off[IDX_W-1:0];
   endfunction : eq_of

   // ----------------------------------------------------------------
   // signal list and current equation
   // ----------------------------------------------------------------
   logic [LIST_N-1:0] sig_list;
   logic [NI-1:0] raw_in;
   logic [DW-1:0] cur_sel;
   logic [SW:0] cur_rsel;
   logic rst_raw;
   logic [NI-1:0] cond_d;
   logic [CNT_W-1:0] cnt_d;
   logic res_d;
   logic lat_d;

   always_comb begin
      sig_list = '0;
      // results live in flops updated in index order, so a lower slot is already
      // fresh when a higher one reads it, and a higher slot still holds last sweep
      sig_list[LIST_W-1:0] = {s_q.latn, s_q.lat, s_q.res, s_q.ext};
      cur_sel = s_q.sel[s_q.idx];
      cur_rsel = s_q.rsel[s_q.idx];
      for (int i = 0; i < NI; i++) begin
         raw_in[i] = pick(sig_list, cur_sel[i*SW +: SW]);
      end
      rst_raw = pick(sig_list, cur_rsel[SW-1:0]);
   end

   equation_eval #(
      .CNT_W(CNT_W)
   ) u_eval (
      .raw_in(raw_in),
      .inv(cur_sel[logic_eq_pkg::INV_LSB +: NI]),
      .gate(logic_eq_pkg::gate_t'(cur_sel[logic_eq_pkg::GATE_LSB +: logic_eq_pkg::GATE_W])),
      .rst_raw(rst_raw),
      .rst_inv(cur_rsel[SW]),
      .assert_delay_time(s_q.on_dly[s_q.idx]),
      .release_delay_time(s_q.off_dly[s_q.idx]),
      .cnt(s_q.cnt[s_q.idx]),
      .res(s_q.res[s_q.idx]),
      .lat(s_q.lat[s_q.idx]),
      .cond(cond_d),
      .cnt_d(cnt_d),
      .res_d(res_d),
      .lat_d(lat_d)
   );

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   logic [IDX_W-1:0] bus_eq;
   logic bus_hit;
   logic [1:0] bus_word;
   logic [DW-1:0] rd_val;
   logic wr_now;

   always_comb begin
      s_d = s_q;
      s_d.tick = 1'b0;
      bus_eq = eq_of(avs_address);
      bus_hit = eq_hit(avs_address);
      bus_word = avs_address[logic_eq_pkg::EQ_STRIDE_SH-1:0];

      // sweep engine: one equation per clock, ascending, wraps while run is set, else goes idle after the last slot
      unique case (s_q.st)
         logic_eq_pkg::ST_IDLE: begin
            s_d.idx = '0;
            if (s_q.run) begin
               s_d.st = logic_eq_pkg::ST_SWEEP;
            end
         end
         logic_eq_pkg::ST_SWEEP: begin
            s_d.cond[s_q.idx] = cond_d;
            s_d.cnt[s_q.idx] = cnt_d;
            s_d.res[s_q.idx] = res_d;
            s_d.lat[s_q.idx] = lat_d;
            s_d.latn[s_q.idx] = ~lat_d;
            if (s_q.idx == LAST_IDX) begin
               // inputs are frozen per sweep so every slot sees one coherent picture
               s_d.ext = {module_input, system_alarm, breaker_state,
                          prot_state, prot_pickup};
               s_d.idx = '0;
               s_d.sweeps = s_q.sweeps + 1'b1;
               s_d.tick = 1'b1;
               if (!s_q.run) begin
                  s_d.st = logic_eq_pkg::ST_IDLE;
               end
            end else begin
               s_d.idx = s_q.idx + 1'b1;
            end
         end
      endcase

      // read mux
      rd_val = '0;
      if (avs_address == logic_eq_pkg::CTRL_ADDR) begin
         rd_val[logic_eq_pkg::CTRL_RUN_BIT] = s_q.run;
      end else if (avs_address == logic_eq_pkg::SWEEP_ADDR) begin
         rd_val[logic_eq_pkg::SWEEP_W-1:0] = s_q.sweeps;
      end else if (bus_hit) begin
         unique case (bus_word)
            logic_eq_pkg::EQ_SEL_WORD: rd_val = s_q.sel[bus_eq];
            logic_eq_pkg::EQ_RST_WORD: begin
               rd_val[SW-1:0] = s_q.rsel[bus_eq][SW-1:0];
               rd_val[logic_eq_pkg::RST_INV_BIT] = s_q.rsel[bus_eq][SW];
            end
            logic_eq_pkg::EQ_DLY_WORD: begin
               rd_val[CNT_W-1:0] = s_q.on_dly[bus_eq];
               rd_val[logic_eq_pkg::OFF_DLY_LSB +: CNT_W] = s_q.off_dly[bus_eq];
            end
            logic_eq_pkg::EQ_STAT_WORD: begin
               rd_val[NI-1:0] = s_q.cond[bus_eq];
               rd_val[logic_eq_pkg::STAT_RES_BIT] = s_q.res[bus_eq];
               rd_val[logic_eq_pkg::STAT_LAT_BIT] = s_q.lat[bus_eq];
               rd_val[logic_eq_pkg::STAT_LATN_BIT] = s_q.latn[bus_eq];
               rd_val[logic_eq_pkg::STAT_BUSY_BIT] = (s_q.cnt[bus_eq] != '0);
            end
         endcase
      end

      // one wait cycle, then a single answer cycle
      wr_now = avs_write && !s_q.wait_r;
      if ((avs_read || avs_write) && s_q.wait_r) begin
         s_d.wait_r = 1'b0;
         s_d.rdata = avs_read ? rd_val : '0;
      end else begin
         s_d.wait_r = 1'b1;
      end

      if (wr_now) begin
         if (avs_address == logic_eq_pkg::CTRL_ADDR) begin
            s_d.run = avs_writedata[logic_eq_pkg::CTRL_RUN_BIT];
         end else if (bus_hit) begin
            unique case (bus_word)
               logic_eq_pkg::EQ_SEL_WORD: begin
                  s_d.sel[bus_eq] = avs_writedata & logic_eq_pkg::SEL_MASK;
               end
               logic_eq_pkg::EQ_RST_WORD: begin
                  s_d.rsel[bus_eq] = {avs_writedata[logic_eq_pkg::RST_INV_BIT],
                                      avs_writedata[SW-1:0]};
               end
               logic_eq_pkg::EQ_DLY_WORD: begin
                  s_d.on_dly[bus_eq] = avs_writedata[CNT_W-1:0];
                  s_d.off_dly[bus_eq] = avs_writedata[logic_eq_pkg::OFF_DLY_LSB +: CNT_W];
               end
               logic_eq_pkg::EQ_STAT_WORD: begin
               end
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (srst) begin
         s_q <= '0;
         s_q.run <= logic_eq_pkg::RUN_RST;
         s_q.st <= logic_eq_pkg::ST_IDLE;
         s_q.wait_r <= 1'b1;
         for (int i = 0; i < N_EQ; i++) begin
            s_q.sel[i] <= logic_eq_pkg::SEL_RST;
            s_q.latn[i] <= 1'b1;
         end
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign equation_result = s_q.res;
   assign latched_result = s_q.lat;
   assign latched_result_n = s_q.latn;
   assign sweep_tick = s_q.tick;
   assign avs_readdata = s_q.rdata;
   assign avs_waitrequest = s_q.wait_r;

endmodule : logic_equations

// ---- logic_equations_asserts.sv ----
// concurrent checks on the ports of the logic equation bank
`timescale 1ns/1ns
module logic_equations_asserts #(
   parameter int N_EQ = 8
) (
   // clock and reset
   input wire logic clock,
   input wire logic srst,
   // bus handshake
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   // equation outputs
   input wire logic [N_EQ-1:0] equation_result,
   input wire logic [N_EQ-1:0] latched_result,
   input wire logic [N_EQ-1:0] latched_result_n,
   input wire logic sweep_tick
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (srst);
   // ----------------------------------------
   // sweep spacing
   // ----------------------------------------
   // saturates, so the first sweep after reset is never taken as short
   logic [7:0] gap_q;
   always_ff @(posedge clock) begin
      if (srst) gap_q <= 8'hFF;
      else if (sweep_tick) gap_q <= 8'h01;
      else if (gap_q != 8'hFF) gap_q <= gap_q + 8'h01;
   end
   tick_gap_a: assert property (sweep_tick |-> gap_q >= N_EQ)
      else $error("sweep shorter than one slot per equation");
   tick_pulse_a: assert property (sweep_tick |=> !sweep_tick)
      else $error("sweep tick longer than one cycle");
   one_slot_a: assert property (
      $onehot0((equation_result ^ $past(equation_result))
         | (latched_result ^ $past(latched_result))))
      else $error("outputs of two equations changed in one cycle");
   wrq_answer_a: assert property (
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("request not answered after one wait cycle");
   wrq_once_a: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("wait request low for more than one cycle");
   wrq_cause_a: assert property (
      $fell(avs_waitrequest) |-> $past(avs_read) || $past(avs_write))
      else $error("answer without a request");
   latch_comp_a: assert property (latched_result_n == ~latched_result)
      else $error("inverted latch output is not the complement");
   latch_set_a: assert property (
      (latched_result & ~$past(latched_result) & ~equation_result) == '0)
      else $error("latch set without a timed result");
   cover property (avs_write && !avs_waitrequest);
   cover property (sweep_tick);
   cover property (|(equation_result & ~latched_result));
endmodule : logic_equations_asserts

// ---- prot_model.sv ----
// behavioural source of the protection-side levels feeding the equation bank
`timescale 1ns/1ns
module prot_model (
   // clock
   input wire logic clock,
   // requested levels, in signal list order
   input wire logic [31:0] ext_req,
   // protection-side signals
   output logic [logic_eq_pkg::PICKUP_W-1:0] prot_pickup,
   output logic [logic_eq_pkg::PSTATE_W-1:0] prot_state,
   output logic [logic_eq_pkg::BREAKER_W-1:0] breaker_state,
   output logic [logic_eq_pkg::ALARM_W-1:0] system_alarm,
   output logic [logic_eq_pkg::MODIN_W-1:0] module_input
);
   // protection functions update once per cycle, never between edges
   logic [31:0] lvl_q = 32'h00000000;
   always_ff @(posedge clock) lvl_q <= ext_req;
   assign {module_input, system_alarm, breaker_state, prot_state, prot_pickup} = lvl_q;
endmodule : prot_model

// ---- tb_top.sv ----
// self-checking bench of the logic equation bank
`timescale 1ns/1ns
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin errors++; \
   $display("wrong value at %0t ns: got %h expected %h", $time, got, exp); end end
module tb_top;
   localparam int N_EQ = 8;
   logic clock = 1'h0;
   logic srst = 1'h1;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'h0;
   logic avs_write = 1'h0;
   logic [31:0] avs_writedata = 32'h00000000;
   logic [31:0] avs_readdata, rd, ext = 32'h00000000;
   logic avs_waitrequest, sweep_tick;
   logic [7:0] prot_pickup, prot_state, module_input;
   logic [3:0] breaker_state, system_alarm;
   logic [N_EQ-1:0] equation_result, latched_result, latched_result_n, prev;
   int errors = 0;
   int check_count = 0;
   int seed = 16;
   int cyc = 0;
   int chg [N_EQ];

   always #50 clock = ~clock;
   // cycle of the latest change of each unlatched output
   always @(posedge clock) begin
      cyc++;
      for (int e = 0; e < N_EQ; e++) if (equation_result[e] !== prev[e]) chg[e] = cyc;
      prev = equation_result;
   end

   logic_equations #(.N_EQ(N_EQ), .CNT_W(16)) DUT (.clock(clock), .srst(srst),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .prot_pickup(prot_pickup), .prot_state(prot_state),
      .breaker_state(breaker_state), .system_alarm(system_alarm), .module_input(module_input),
      .equation_result(equation_result), .latched_result(latched_result),
      .latched_result_n(latched_result_n), .sweep_tick(sweep_tick));
   prot_model PM (.clock(clock), .ext_req(ext), .prot_pickup(prot_pickup),
      .prot_state(prot_state), .breaker_state(breaker_state), .system_alarm(system_alarm),
      .module_input(module_input));

   // ----------------------------------------
   // bench tasks and reference functions
   // ----------------------------------------
   task automatic give_verdict();
      $display("comparisons %0d, mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : give_verdict

   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge clock);
      avs_address <= a;
      avs_writedata <= wd;
      avs_write <= wr;
      avs_read <= !wr;
      do begin
         @(posedge clock);
         n++;
      end while (avs_waitrequest !== 1'h0 && n < 20);
      rd = avs_readdata;
      avs_write <= 1'h0;
      avs_read <= 1'h0;
      if (avs_waitrequest !== 1'h0) begin
         errors++;
         give_verdict();
      end
   endtask : bus

   task automatic sweeps(input int k);
      int n;
      n = 0;
      while (k > 0 && n < 100 * N_EQ) begin
         @(posedge clock);
         n++;
         if (sweep_tick === 1'h1) k--;
      end
      if (k > 0) begin
         errors++;
         give_verdict();
      end
   endtask : sweeps

   function automatic logic [7:0] ea(input int e, input int w);
      return logic_eq_pkg::EQ_BASE_ADDR + 8'(e * 4 + w);
   endfunction : ea

   function automatic logic gate_fn(input logic [1:0] g, input logic [3:0] c);
      case (g)
         2'h0: return &c;
         2'h1: return |c;
         2'h2: return ~&c;
         default: return ~|c;
      endcase
   endfunction : gate_fn

   initial begin
      logic [3:0] inv, c;
      logic [31:0] r;
      logic [5:0] src [6];
      logic x;
      logic [15:0] cnt0;
      src = '{6'h00, 6'h22, 6'h04, 6'h22, 6'h04, 6'h04};
      repeat (20) @(posedge clock);
      srst <= 1'h0;
      `CHK({equation_result, latched_result}, {2 * N_EQ{1'h0}})
      `CHK(latched_result_n, {N_EQ{1'h1}})
      bus(1'h0, logic_eq_pkg::CTRL_ADDR, 32'h00000000);
      `CHK(rd[0], logic_eq_pkg::RUN_RST)
      bus(1'h0, ea(3, 0), 32'h00000000);
      `CHK(rd, logic_eq_pkg::SEL_RST)
      bus(1'h1, 8'hFF, 32'hFFFFFFFF);
      bus(1'h0, 8'hFF, 32'h00000000);
      `CHK(rd, 32'h00000000)
      bus(1'h1, ea(6, 3), 32'hFFFFFFFF);
      bus(1'h0, ea(6, 3), 32'h00000000);
      `CHK(rd, 32'h00000040)
      r = $random(seed);
      bus(1'h1, ea(7, 0), r);
      bus(1'h0, ea(7, 0), 32'h00000000);
      `CHK(rd, r & logic_eq_pkg::SEL_MASK)
      bus(1'h1, ea(7, 1), ~r);
      bus(1'h0, ea(7, 1), 32'h00000000);
      `CHK(rd, ~r & logic_eq_pkg::RST_MASK)
      $display("test registers done");
      bus(1'h1, ea(0, 2), 32'h00000000);
      for (int k = 0; k < 16; k++) begin
         inv = 4'($random(seed));
         ext[3:0] <= 4'($random(seed));
         bus(1'h1, ea(0, 0), {2'h0, k[1:0], inv, 6'h03, 6'h02, 6'h01, 6'h00});
         sweeps(3);
         c = ext[3:0] ^ inv;
         x = gate_fn(k[1:0], c);
         `CHK(equation_result[0], x)
         bus(1'h0, ea(0, 3), 32'h00000000);
         `CHK(rd[4:0], {x, c})
      end
      $display("test gates done");
      for (int e = 1; e < 6; e++) begin
         bus(1'h1, ea(e, 0), {8'h00, src[e], src[e], src[e], src[e]});
         bus(1'h1, ea(e, 2), (e == 4) ? 32'h00020003 : 32'h00000000);
      end
      bus(1'h1, ea(5, 1), 32'h00000018);
      sweeps(2);
      for (int d = 0; d < 2; d++) begin
         ext[4] <= !d[0];
         sweeps(5);
         `CHK(equation_result[5:1], d ? 5'h00 : 5'h1F)
         `CHK(chg[3] - chg[2], 1)
         `CHK(chg[1] - chg[2], N_EQ - 1)
         `CHK(chg[4] - chg[2], d ? N_EQ + 2 : 2 * N_EQ + 2)
         `CHK(latched_result[5], 1'h1)
      end
      $display("test cascade done");
      ext[24] <= 1'h1;
      sweeps(2);
      `CHK(latched_result[5], 1'h0)
      ext[4] <= 1'h1;
      sweeps(3);
      `CHK({equation_result[5], latched_result[5]}, 2'h2)
      bus(1'h0, ea(5, 3), 32'h00000000);
      `CHK(rd[6:4], 3'h5)
      bus(1'h1, ea(5, 1), 32'h00000118);
      ext[4] <= 1'h0;
      sweeps(2);
      ext[4] <= 1'h1;
      sweeps(2);
      `CHK(latched_result[5], 1'h1)
      ext[24] <= 1'h0;
      sweeps(2);
      `CHK(latched_result[5], 1'h0)
      $display("test latch done");
      // stop after the running sweep, counter must freeze, then resume
      bus(1'h1, logic_eq_pkg::CTRL_ADDR, 32'h00000000);
      repeat (2 * N_EQ) @(posedge clock);
      bus(1'h0, logic_eq_pkg::SWEEP_ADDR, 32'h00000000);
      cnt0 = rd[15:0];
      repeat (2 * N_EQ) @(posedge clock);
      bus(1'h0, logic_eq_pkg::SWEEP_ADDR, 32'h00000000);
      `CHK(rd, {16'h0000, cnt0})
      bus(1'h0, logic_eq_pkg::CTRL_ADDR, 32'h00000000);
      `CHK(rd, 32'h00000000)
      bus(1'h1, logic_eq_pkg::CTRL_ADDR, 32'h00000001);
      sweeps(3);
      bus(1'h0, logic_eq_pkg::SWEEP_ADDR, 32'h00000000);
      `CHK(rd, {16'h0000, cnt0 + 16'h0003})
      $display("test run control done");
      give_verdict();
   end
endmodule : tb_top

bind logic_equations logic_equations_asserts #(.N_EQ(N_EQ)) chk_i (.clock(clock),
   .srst(srst), .avs_read(avs_read), .avs_write(avs_write),
   .avs_waitrequest(avs_waitrequest), .equation_result(equation_result),
   .latched_result(latched_result), .latched_result_n(latched_result_n),
   .sweep_tick(sweep_tick));
